// >>> hdl/adc_ctl_cfg.svh
// register offsets, field positions, reset values and conversion timing counts
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OFS_SELECT 12'h000
`define OFS_CONTROL 12'h004
`define OFS_RESULT 12'h008
`define OFS_TRIGGER 12'h00C
`define OFS_APPLIED 12'h010

// ****************************************************************
// field positions
// ****************************************************************
`define SEL_REF_HI 7
`define SEL_REF_LO 6
`define SEL_LEFT 5
`define SEL_CH_HI 3
`define CTL_ENABLE 7
`define CTL_START 6
`define CTL_AUTO 5
`define CTL_DONE 4
`define CTL_IE 3
`define CTL_PS_HI 2
`define APPLIED_BUSY 8

// ****************************************************************
// reset values
// ****************************************************************
`define CHANNEL_RESET 4'h0
`define REFERENCE_RESET 2'h0
`define PRESCALE_RESET 3'h0
`define TRIGSEL_RESET 3'h0
`define RESULT_RESET 10'h000

// ****************************************************************
// timing in converter clock cycles
// ****************************************************************
`define NORMAL_SAMPLE 5'd1
`define NORMAL_LAST 5'd12
`define FIRST_SAMPLE 5'd13
`define FIRST_LAST 5'd24
`define SAR_DECISIONS 5'd10
`define SAR_FIRST_TRIAL 10'h200

`endif

// >>> hdl/adc_ctl_pkg.sv
// types shared by the converter control design
package adc_ctl_pkg;

  // processor sleep state as reported by the core
  typedef enum logic [2:0] {
    SLEEP_IDLE,
    SLEEP_NOISE_REDUCTION,
    SLEEP_POWER_DOWN,
    SLEEP_POWER_SAVE,
    SLEEP_STANDBY
  } sleep_mode_t;

  // conversion sequencer
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_CONVERT
  } conv_state_t;

endpackage

// >>> hdl/adc_selection_and_sleep_control.sv
// converter control: selection buffering, conversion sequencing and sleep start
//
// Contract
// - selection written by software lives in a readable temporary register.
// - while idle, temporary selection is copied to the applied selection every cycle.
// - a starting conversion freezes the applied selection.
// - copying resumes in the last converter cycle before the done flag.
// - a software start begins at the next converter clock tick.
// - free-running change after completion applies from the conversion after next.
// - halted core in idle or noise-reduction sleep starts a prepared conversion.
// - conversion-complete request wakes the core when nothing else did.
// - request is still raised if another interrupt woke the core first.
// - other sleep modes leave the converter enabled.
// - input at or above reference yields the full-scale code.
// - start bit reads one during a conversion, cleared by hardware at completion.
// - auto trigger edge resets the prescaler and starts a conversion.
// - completion writes the result and sets the done flag.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`include "adc_ctl_cfg.svh"

module adc_selection_and_sleep_control #(
  parameter int TRIG_WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // processor core
  input wire adc_ctl_pkg::sleep_mode_t sleep_mode,
  input wire logic cpu_halted,
  input wire logic irq_ack,
  output logic irq_conversion_done,
  // trigger sources, same clock
  input wire logic [TRIG_WIDTH-1:0] trigger_sources,
  // analog front end
  input wire logic comparator_in,
  output logic [3:0] channel_applied,
  output logic [1:0] reference_applied,
  output logic converter_powered,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic conversion_active
);
  import adc_ctl_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [3:0] channel_select_reg;
  logic [1:0] reference_select_reg;
  logic left_adjust_reg;
  logic converter_enable_reg;
  logic auto_trigger_enable_reg;
  logic irq_enable_reg;
  logic [2:0] prescale_reg;
  logic [2:0] trigger_select_reg;
  logic conversion_done_flag_reg;
  logic first_pending_reg;
  logic first_conv_reg;
  logic lock_reg;
  logic [6:0] prescale_cnt_reg;
  logic [4:0] cycle_reg;
  logic [9:0] result_reg;
  logic trig_prev_reg;
  logic halted_prev_reg;
  conv_state_t state_reg;
  logic comparator_sync;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // last prescaler count for a division setting; settings 0 and 1 both divide by two
  function automatic logic [6:0] div_last(input logic [2:0] ps);
    div_last = (ps == 3'h0) ? 7'h01 : 7'((8'h01 << ps) - 8'h01);
  endfunction

  // one successive-approximation step on bit k
  function automatic logic [9:0] sar_step(input logic [9:0] code, input logic [4:0] k,
                                          input logic keep);
    logic [9:0] mask;
    mask = 10'h001 << k;
    sar_step = keep ? code : (code & ~mask);
    if (k != 5'd0)
      sar_step = sar_step | (mask >> 1);
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic wr;
  logic setup;
  logic wr_sel;
  logic wr_ctl;
  logic start_req;
  logic done_clear;
  logic mapped;

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign wr_sel = wr && (paddr == `OFS_SELECT);
  assign wr_ctl = wr && (paddr == `OFS_CONTROL);
  assign start_req = wr_ctl && pwdata[`CTL_START];
  assign done_clear = (wr_ctl && pwdata[`CTL_DONE]) || irq_ack;
  assign mapped = (paddr == `OFS_SELECT) || (paddr == `OFS_CONTROL) ||
                  (paddr == `OFS_RESULT) || (paddr == `OFS_TRIGGER) ||
                  (paddr == `OFS_APPLIED);
  assign pready = psel && penable;

  input_sync #(.WIDTH(1)) u_cmp_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(comparator_in),
    .sync_out(comparator_sync)
  );

  // ****************************************************************
  // timing and start conditions
  // ****************************************************************
  logic tick;
  logic trig_src;
  logic trig_start;
  logic sleep_start;
  logic free_running;
  logic [4:0] sample_cyc;
  logic [4:0] last_cyc;
  logic complete;

  assign tick = converter_enable_reg && (prescale_cnt_reg == div_last(prescale_reg));
  assign trig_src = (trigger_select_reg == 3'h0) ? conversion_done_flag_reg :
                    trigger_sources[trigger_select_reg];
  // edges during a conversion are ignored
  assign trig_start = converter_enable_reg && auto_trigger_enable_reg && trig_src &&
                      !trig_prev_reg && (state_reg == ST_IDLE);
  assign sleep_start = converter_enable_reg && !auto_trigger_enable_reg && irq_enable_reg &&
                       (state_reg == ST_IDLE) && cpu_halted && !halted_prev_reg &&
                       ((sleep_mode == SLEEP_IDLE) ||
                        (sleep_mode == SLEEP_NOISE_REDUCTION));
  assign free_running = auto_trigger_enable_reg && (trigger_select_reg == 3'h0);
  assign sample_cyc = first_conv_reg ? `FIRST_SAMPLE : `NORMAL_SAMPLE;
  assign last_cyc = first_conv_reg ? `FIRST_LAST : `NORMAL_LAST;
  assign complete = tick && (state_reg == ST_CONVERT) && (cycle_reg == last_cyc);

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_select_reg <= `CHANNEL_RESET;
      reference_select_reg <= `REFERENCE_RESET;
      left_adjust_reg <= 1'b0;
    end
    else if (wr_sel)
    begin
      channel_select_reg <= pwdata[`SEL_CH_HI:0];
      reference_select_reg <= pwdata[`SEL_REF_HI:`SEL_REF_LO];
      left_adjust_reg <= pwdata[`SEL_LEFT];
    end
  end

  // sleep never touches the enable; only software clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      converter_enable_reg <= 1'b0;
      auto_trigger_enable_reg <= 1'b0;
      irq_enable_reg <= 1'b0;
      prescale_reg <= `PRESCALE_RESET;
      trigger_select_reg <= `TRIGSEL_RESET;
    end
    else
    begin
      if (wr_ctl)
      begin
        converter_enable_reg <= pwdata[`CTL_ENABLE];
        auto_trigger_enable_reg <= pwdata[`CTL_AUTO];
        irq_enable_reg <= pwdata[`CTL_IE];
        prescale_reg <= pwdata[`CTL_PS_HI:0];
      end
      if (wr && (paddr == `OFS_TRIGGER))
        trigger_select_reg <= pwdata[2:0];
    end
  end

  // done flag: a completion in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      conversion_done_flag_reg <= 1'b0;
    else if (complete)
      conversion_done_flag_reg <= 1'b1;
    else if (done_clear)
      conversion_done_flag_reg <= 1'b0;
  end

  // ****************************************************************
  // applied selection
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_applied <= `CHANNEL_RESET;
      reference_applied <= `REFERENCE_RESET;
    end
    else if (!lock_reg)
    begin
      channel_applied <= channel_select_reg;
      reference_applied <= reference_select_reg;
    end
  end

  // ****************************************************************
  // prescaler and edge history
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale_cnt_reg <= 7'h00;
    else if (!converter_enable_reg || trig_start || tick)
      prescale_cnt_reg <= 7'h00;
    else
      prescale_cnt_reg <= prescale_cnt_reg + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_prev_reg <= 1'b0;
      halted_prev_reg <= 1'b0;
    end
    else
    begin
      trig_prev_reg <= trig_src;
      halted_prev_reg <= cpu_halted;
    end
  end

  // ****************************************************************
  // conversion sequencer
  // ****************************************************************
  // clearing the enable aborts any conversion in flight
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      cycle_reg <= 5'd0;
      lock_reg <= 1'b0;
      first_conv_reg <= 1'b0;
      first_pending_reg <= 1'b0;
    end
    else if (!converter_enable_reg)
    begin
      // a start written together with the enable arms the first, long conversion
      state_reg <= (start_req && pwdata[`CTL_ENABLE]) ? ST_ARMED : ST_IDLE;
      lock_reg <= 1'b0;
      first_pending_reg <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_req || sleep_start || trig_start)
            state_reg <= ST_ARMED;
        end
        ST_ARMED:
        begin
          if (tick)
          begin
            state_reg <= ST_CONVERT;
            cycle_reg <= 5'd0;
            lock_reg <= 1'b1;
            first_conv_reg <= first_pending_reg;
            first_pending_reg <= 1'b0;
          end
        end
        ST_CONVERT:
        begin
          if (tick)
          begin
            if (cycle_reg == last_cyc)
            begin
              cycle_reg <= 5'd0;
              first_conv_reg <= 1'b0;
              // restart at once; applied copy taken in the final cycle is used
              if (free_running)
                lock_reg <= 1'b1;
              else
                state_reg <= ST_IDLE;
            end
            else
            begin
              cycle_reg <= cycle_reg + 5'd1;
              if (cycle_reg == last_cyc - 5'd1)
                lock_reg <= 1'b0;
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // successive approximation
  // ****************************************************************
  // comparator high means input at or above the trial level, so a full-scale input keeps all ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dac_code <= 10'h000;
      result_reg <= `RESULT_RESET;
      sample_hold <= 1'b0;
    end
    else
    begin
      sample_hold <= 1'b0;
      if (tick && (state_reg == ST_CONVERT))
      begin
        if (cycle_reg == sample_cyc)
        begin
          dac_code <= `SAR_FIRST_TRIAL;
          sample_hold <= 1'b1;
        end
        else if ((cycle_reg > sample_cyc) && (cycle_reg <= sample_cyc + `SAR_DECISIONS))
          dac_code <= sar_step(dac_code, sample_cyc + `SAR_DECISIONS - cycle_reg,
                               comparator_sync);
        if (complete)
          result_reg <= dac_code;
      end
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      pslverr <= !mapped;
      case (paddr)
        `OFS_SELECT:
          prdata <= {24'h000000, reference_select_reg, left_adjust_reg, 1'b0,
                     channel_select_reg};
        `OFS_CONTROL:
          prdata <= {24'h000000, converter_enable_reg, state_reg != ST_IDLE,
                     auto_trigger_enable_reg, conversion_done_flag_reg, irq_enable_reg,
                     prescale_reg};
        `OFS_RESULT:
          prdata <= left_adjust_reg ? {16'h0000, result_reg, 6'h00} :
                                      {22'h000000, result_reg};
        `OFS_TRIGGER:
          prdata <= {29'h00000000, trigger_select_reg};
        `OFS_APPLIED:
          prdata <= {23'h000000, lock_reg, reference_applied, 2'h0, channel_applied};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // request stands until acknowledged, whatever woke the core
  assign irq_conversion_done = conversion_done_flag_reg && irq_enable_reg;
  assign converter_powered = converter_enable_reg;
  assign conversion_active = (state_reg == ST_CONVERT);

endmodule // adc_selection_and_sleep_control

// >>> hdl/input_sync.sv
// three-stage synchroniser with agreement filter for asynchronous inputs
module input_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // signals
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_out <= '0;
    else
    begin
      for (int i = 0; i < WIDTH; i++)
      begin
        if (stage2_reg[i] == stage3_reg[i])
          sync_out[i] <= stage2_reg[i];
      end
    end
  end

endmodule // input_sync

// >>> test/adc_ctl_props.sv
// assertion checker for the converter control block ports
`include "adc_ctl_cfg.svh"
module adc_ctl_props #(
  parameter int TRIG_WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // core
  input wire logic irq_ack,
  input wire logic irq_conversion_done,
  // converter
  input wire logic [3:0] channel_applied,
  input wire logic [1:0] reference_applied,
  input wire logic converter_powered,
  input wire logic sample_hold,
  input wire logic [9:0] dac_code,
  input wire logic conversion_active
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ctl_wr;
  logic sel_wr;
  logic mapped;
  assign ctl_wr = psel && penable && pwrite && paddr == `OFS_CONTROL;
  assign sel_wr = psel && penable && pwrite && paddr == `OFS_SELECT;
  assign mapped = paddr inside {`OFS_SELECT, `OFS_CONTROL, `OFS_RESULT, `OFS_TRIGGER, `OFS_APPLIED};
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_no_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access cycle");
  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_copy_idle: assert property (sel_wr && !conversion_active ##1 !conversion_active
    ##1 !conversion_active |-> channel_applied == $past(pwdata[3:0], 2)
    && reference_applied == $past(pwdata[7:6], 2))
    else $error("idle selection not applied");
  a_lock_hold: assert property ($rose(conversion_active) |=>
    ($stable(channel_applied) && $stable(reference_applied)) [*8])
    else $error("selection moved during conversion");
  // the start edge itself must not begin the conversion
  a_start_next_tick: assert property (ctl_wr && pwdata[`CTL_ENABLE] && pwdata[`CTL_START]
    && !pwdata[`CTL_AUTO] && !conversion_active |=> !conversion_active ##[1:260] conversion_active)
    else $error("start not taken at next tick");
  a_first_trial: assert property (sample_hold |-> dac_code == `SAR_FIRST_TRIAL && conversion_active)
    else $error("wrong trial at sample point");
  a_power_follows: assert property (ctl_wr |=> converter_powered == $past(pwdata[`CTL_ENABLE]))
    else $error("converter power not following enable");
  a_irq_fall_cause: assert property ($fell(irq_conversion_done) |-> $past(irq_ack) || $past(ctl_wr))
    else $error("interrupt dropped without cause");
  a_irq_rise_cause: assert property ($rose(irq_conversion_done) |->
    $past(conversion_active) || $past(ctl_wr))
    else $error("interrupt raised without completion");
  cover property (sample_hold);
  cover property ($fell(irq_conversion_done));
  cover property (sel_wr ##1 !conversion_active);
endmodule // adc_ctl_props

bind adc_selection_and_sleep_control adc_ctl_props #(.TRIG_WIDTH(TRIG_WIDTH)) adc_ctl_props_inst (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
  .irq_ack, .irq_conversion_done, .channel_applied, .reference_applied, .converter_powered,
  .sample_hold, .dac_code, .conversion_active);

// >>> test/adc_front_model.sv
// analog front end model: fixed level per channel and an ideal comparator
module adc_front_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // converter side
  input wire logic [3:0] channel_applied,
  input wire logic [9:0] dac_code,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] level;
  // channel 15 sits above the reference; levels move only in a conversion's last cycle, after the final decision
  assign level = {7'h00, channel_applied} * 11'h046 + 11'h005;
  // reference is not modelled, so no result needs discarding
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      comparator_in <= 1'b0;
    else
      comparator_in <= ({1'b0, dac_code} <= level);
  end
endmodule // adc_front_model

// >>> test/testbench.sv
// self-checking bench for the converter control block
`include "adc_ctl_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic irq_ack, irq_conversion_done, cpu_halted, comparator_in;
  logic converter_powered, sample_hold, conversion_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] trigger_sources;
  logic [3:0] channel_applied, ch, nch;
  logic [1:0] reference_applied, rf;
  logic [9:0] dac_code;
  adc_ctl_pkg::sleep_mode_t sleep_mode;
  int seed = 55;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  adc_selection_and_sleep_control #(.TRIG_WIDTH(8)) adc_selection_and_sleep_control_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .sleep_mode, .cpu_halted, .irq_ack, .irq_conversion_done, .trigger_sources, .comparator_in,
    .channel_applied, .reference_applied, .converter_powered, .sample_hold, .dac_code,
    .conversion_active);
  adc_front_model adc_front_model_inst (.pclk, .presetn, .channel_applied, .dac_code,
    .comparator_in);
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_hi(input logic irq);
    int n;
    n = 0;
    // look at settled outputs on the falling edge, resume on a rising one
    @(negedge pclk);
    while ((irq ? irq_conversion_done : conversion_active) !== 1'b1 && n < 5000)
    begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    if (n == 5000)
      chk("wait_limit", 32'h0, 32'h1);
  endtask
  function automatic logic [31:0] code(input logic [3:0] c);
    logic [10:0] v;
    v = {7'h00, c} * 11'h046 + 11'h005;
    code = (v > 11'h3FF) ? 32'h3FF : {22'h0, v[9:0]};
  endfunction
  // enable and irq enable always on, divide by 8; m is start, auto, done-clear
  function automatic logic [31:0] ctl(input logic [2:0] m);
    ctl = {24'h0, 1'b1, m[2:1], m[0], 1'b1, 3'h3};
  endfunction
  task automatic give_verdict();
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    presetn = 1'b0;
    {paddr, psel, penable, pwrite, pwdata, irq_ack, cpu_halted, trigger_sources} = '0;
    sleep_mode = adc_ctl_pkg::SLEEP_IDLE;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("out_reset", 32'h0, {reference_applied, conversion_active, channel_applied});
    apb(`OFS_APPLIED, 1'b0, 32'h0);
    chk("applied_reset", 32'h0, rd);
    apb(12'h014, 1'b0, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    for (int i = 0; i < 4; i++)
    begin
      ch = (i == 0) ? 4'hF : 4'($random(seed));
      rf = 2'($random(seed));
      nch = ~ch;
      apb(`OFS_SELECT, 1'b1, {24'h0, rf, 2'h0, ch});
      apb(`OFS_SELECT, 1'b0, 32'h0);
      chk("select_rd", {24'h0, rf, 2'h0, ch}, rd);
      apb(`OFS_APPLIED, 1'b0, 32'h0);
      chk("applied_idle", {24'h0, rf, 2'h0, ch}, rd);
      apb(`OFS_CONTROL, 1'b1, ctl(3'h4));
      wait_hi(1'b0);
      // one converter clock at divide by 8
      repeat (8) @(posedge pclk);
      apb(`OFS_SELECT, 1'b1, {24'h0, rf, 2'h0, nch});
      apb(`OFS_CONTROL, 1'b0, 32'h0);
      chk("start_busy", 32'h1, rd[6]);
      chk("chan_locked", ch, channel_applied);
      wait_hi(1'b1);
      apb(`OFS_RESULT, 1'b0, 32'h0);
      chk("result", code(ch), rd);
      apb(`OFS_CONTROL, 1'b0, 32'h0);
      chk("start_done", 32'h1, {rd[6], rd[4]});
      chk("chan_after", nch, channel_applied);
      apb(`OFS_CONTROL, 1'b1, ctl(3'h1));
    end
    for (int k = 0; k < 2; k++)
    begin
      ch = 4'($random(seed));
      apb(`OFS_SELECT, 1'b1, {28'h0, ch});
      sleep_mode <= k ? adc_ctl_pkg::SLEEP_IDLE : adc_ctl_pkg::SLEEP_NOISE_REDUCTION;
      cpu_halted <= 1'b1;
      wait_hi(1'b0);
      // second pass: some other source wakes the core mid conversion
      cpu_halted <= (k == 0);
      wait_hi(1'b1);
      apb(`OFS_RESULT, 1'b0, 32'h0);
      chk("sleep_result", code(ch), rd);
      irq_ack <= 1'b1;
      cpu_halted <= 1'b0;
      @(posedge pclk);
      irq_ack <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("ack_clear", 32'h0, irq_conversion_done);
    end
    sleep_mode <= adc_ctl_pkg::SLEEP_POWER_DOWN;
    cpu_halted <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("sleep_other", 32'h2, {converter_powered, conversion_active});
    cpu_halted <= 1'b0;
    ch = 4'($random(seed));
    apb(`OFS_SELECT, 1'b1, {28'h0, ch});
    apb(`OFS_TRIGGER, 1'b1, 32'h1);
    apb(`OFS_CONTROL, 1'b1, ctl(3'h2));
    trigger_sources <= 8'($random(seed)) & 8'hFD;
    @(posedge pclk);
    trigger_sources <= trigger_sources | 8'h02;
    wait_hi(1'b0);
    wait_hi(1'b1);
    apb(`OFS_RESULT, 1'b0, 32'h0);
    chk("trig_result", code(ch), rd);
    trigger_sources <= 8'h00;
    ch = 4'($random(seed));
    nch = ~ch;
    apb(`OFS_TRIGGER, 1'b1, 32'h0);
    apb(`OFS_SELECT, 1'b1, {28'h0, ch});
    apb(`OFS_CONTROL, 1'b1, ctl(3'h7));
    wait_hi(1'b1);
    apb(`OFS_SELECT, 1'b1, {28'h0, nch});
    apb(`OFS_CONTROL, 1'b1, ctl(3'h3));
    wait_hi(1'b1);
    apb(`OFS_RESULT, 1'b0, 32'h0);
    chk("free_old", code(ch), rd);
    apb(`OFS_CONTROL, 1'b1, ctl(3'h3));
    wait_hi(1'b1);
    apb(`OFS_RESULT, 1'b0, 32'h0);
    chk("free_new", code(nch), rd);
    apb(`OFS_CONTROL, 1'b1, 32'h10);
    chk("disabled", 32'h0, converter_powered);
    give_verdict();
  end
endmodule // testbench
